// file: design/ascii_cmd_pkg.sv
// Constants, types and keyword table for the ASCII command message parser
package ascii_cmd_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int          DATA_W     = 8;
  localparam int          FIFO_DEPTH = 32;
  localparam int          KW_MAX     = 12;
  localparam int          KW_BUF_W   = 8 * KW_MAX;
  localparam int          KW_NUM     = 21;
  localparam int          MODULE_MAX = 27;
  localparam logic [3:0]  LEN_SAT    = 4'hD;

  typedef logic [4:0] kw_id_t;
  typedef logic [4:0] node_t;

  // ****************************************************************
  // Character codes
  // ****************************************************************
  localparam logic [7:0]  CH_LF    = 8'h0A;
  localparam logic [7:0]  CH_CR    = 8'h0D;
  localparam logic [7:0]  CH_SPACE = 8'h20;
  localparam logic [7:0]  CH_0     = 8'h30;
  localparam logic [7:0]  CH_9     = 8'h39;
  localparam logic [7:0]  CH_COLON = 8'h3A;
  localparam logic [7:0]  CH_SEMI  = 8'h3B;
  localparam logic [7:0]  CH_QUERY = 8'h3F;
  localparam logic [7:0]  CH_A     = 8'h41;
  localparam logic [7:0]  CH_Z     = 8'h5A;
  localparam logic [7:0]  CH_LA    = 8'h61;
  localparam logic [7:0]  CH_LZ    = 8'h7A;
  localparam logic [7:0]  CASE_OFS = 8'h20;
  localparam logic [39:0] VOWELS   = 40'h41_45_49_4F_55;

  // ****************************************************************
  // Node numbers and reset values
  // ****************************************************************
  localparam logic [6:0]  NODE_MIN   = 7'h01;
  localparam logic [6:0]  NODE_MAX   = 7'h1F;
  localparam node_t       NODE_RESET = 5'h01;
  localparam logic [6:0]  NUM_SAT    = 7'h7F;
  localparam logic [10:0] NUM_TEN    = 11'h00A;

  typedef enum logic [2:0] {
    ST_START = 3'b000,
    ST_WORD  = 3'b001,
    ST_NODE  = 3'b010,
    ST_TAIL  = 3'b011,
    ST_PARAM = 3'b100,
    ST_SKIP  = 3'b101
  } parse_state_e;

  // ****************************************************************
  // Command tree: long form names, right aligned, and two parents
  // ****************************************************************
  localparam kw_id_t KW_ROOT = 5'h00;
  localparam kw_id_t KW_SOUR = 5'h04;
  localparam kw_id_t KW_SEL  = 5'h0B;

  localparam logic [KW_BUF_W-1:0] KW_NAME [1:KW_NUM] = '{
    "INITIATE", "MEASURE", "OUTPUT", "SOURCE", "STATUS", "SYSTEM",
    "VOLTAGE", "CURRENT", "FUNCTION", "INSTRUMENT", "SELECT", "OPERATION",
    "PRESET", "QUESTIONABLE", "CONDITION", "ENABLE", "MODE", "LEVEL",
    "TRIGGER", "ERROR", "IMMEDIATE"};
  localparam kw_id_t KW_PA [1:KW_NUM] = '{
    5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h04, 5'h04, 5'h04, 5'h00, 5'h0A,
    5'h05, 5'h05, 5'h05, 5'h0C, 5'h0C, 5'h09, 5'h07, 5'h12, 5'h06, 5'h12};
  localparam kw_id_t KW_PB [1:KW_NUM] = '{
    5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h00, 5'h02, 5'h02, 5'h04, 5'h00, 5'h0A,
    5'h05, 5'h05, 5'h05, 5'h0E, 5'h0E, 5'h09, 5'h08, 5'h07, 5'h06, 5'h01};

  function automatic int kw_len(input logic [KW_BUF_W-1:0] name);
    int n;
    n = 0;
    for (int i = 0; i < KW_MAX; i++) begin
      if (name[8*i +: 8] != 8'h00) n = i + 1;
    end
    return n;
  endfunction : kw_len

  // Short form length from the long form
  function automatic int kw_short(input logic [KW_BUF_W-1:0] name);
    int         n;
    logic [7:0] c4;
    logic       vow;
    n   = kw_len(name);
    c4  = 8'h00;
    vow = 1'b0;
    if (n > 4) c4 = name[8*(n-4) +: 8];
    for (int i = 0; i < 5; i++) begin
      if (c4 == VOWELS[8*i +: 8]) vow = 1'b1;
    end
    if (n <= 4) return n;
    return vow ? 3 : 4;
  endfunction : kw_short

endpackage : ascii_cmd_pkg

// file: design/ascii_command_message_parser.sv
// Input FIFO and ASCII program message parser
`timescale 1ns/100ps

// ****************************************************************
// Byte FIFO
// ****************************************************************
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             wr_valid,
  output      logic             wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  output      logic             rd_valid,
  input  wire logic             rd_ready,
  output      logic [WIDTH-1:0] rd_data
);
  // Depth must be a power of two: pointers wrap naturally
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  logic [AW:0]      fill;

  assign fill     = wr_ptr_reg - rd_ptr_reg;
  assign wr_ready = fill != (AW+1)'(DEPTH);
  assign rd_valid = fill != '0;
  assign rd_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (wr_valid && wr_ready) mem[wr_ptr_reg[AW-1:0]] <= wr_data;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (wr_valid && wr_ready) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (rd_valid && rd_ready) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule : byte_fifo

// ****************************************************************
// Parser
// ****************************************************************
// Summary of operation
// - Parameter follows last keyword after one space
// - Short form: whole, first four, or three
// - Any other abbreviation is an error
// - Keyword letters matched regardless of case
// - Colon between keywords descends one level
// - Question mark after last keyword makes query
// - Semicolon splits message units
// - Leading colon returns tree position to root
// - LF, CR or CR LF end message
// - Terminator or root colon returns to root
// - Source keyword optional at root
// - After semicolon resolve at previous unit's level
// - Node numbers 1 to 31, 27 modules
// - Digits appended to keyword select node
// - Node 1 after reset; given node sticks
// - Instrument select argument changes default node
module ascii_command_message_parser (
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  input  wire logic                       rx_valid,
  output      logic                       rx_ready,
  input  wire logic [7:0]                 rx_data,
  output      logic                       cmd_valid,
  input  wire logic                       cmd_ready,
  output      logic                       cmd_param,
  output      logic [7:0]                 cmd_byte,
  output      ascii_cmd_pkg::kw_id_t      cmd_kw,
  output      logic                       cmd_query,
  output      ascii_cmd_pkg::node_t       cmd_node,
  output      logic                       cmd_eom,
  output      logic                       parse_err
);
  import ascii_cmd_pkg::*;

  parse_state_e          state_reg;
  parse_state_e          state_next;
  kw_id_t                cur_reg;
  kw_id_t                base_reg;
  kw_id_t                last_reg;
  kw_id_t                kw_found;
  node_t                 node_reg;
  node_t                 node_now;
  logic [KW_BUF_W-1:0]   buf_reg;
  logic [3:0]            len_reg;
  logic [6:0]            num_reg;
  logic [6:0]            num_sat;
  logic [10:0]           num_mul;
  logic [7:0]            f_data;
  logic [7:0]            ch;
  logic [7:0]            dsub;
  logic [KW_NUM:1]       hit;
  logic                  f_valid;
  logic                  out_free;
  logic                  take;
  logic                  step;
  logic                  is_alpha;
  logic                  is_digit;
  logic                  is_term;
  logic                  kw_ok;
  logic                  kw_end;
  logic                  node_end;
  logic                  unit_end;
  logic                  pbyte;
  logic                  perr;
  logic                  go_root;
  logic                  sel_fire;
  logic                  query_reg;
  logic                  pdig_reg;
  logic                  cr_reg;
  logic                  semi_reg;
  logic                  cmd_valid_reg;
  logic                  cmd_param_reg;
  logic [7:0]            cmd_byte_reg;
  kw_id_t                cmd_kw_reg;
  logic                  cmd_query_reg;
  node_t                 cmd_node_reg;
  logic                  cmd_eom_reg;
  logic                  parse_err_reg;

  // ****************************************************************
  // Input buffering and byte classes
  // ****************************************************************
  // A held result stalls the parser, which in turn fills the FIFO
  assign out_free = !cmd_valid_reg || cmd_ready;

  byte_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .wr_valid (rx_valid),
    .wr_ready (rx_ready),
    .wr_data  (rx_data),
    .rd_valid (f_valid),
    .rd_ready (out_free),
    .rd_data  (f_data)
  );

  assign take     = f_valid && out_free;
  assign step     = take && !(cr_reg && f_data == CH_LF);
  assign ch       = (f_data >= CH_LA && f_data <= CH_LZ) ? f_data - CASE_OFS : f_data;
  assign is_alpha = ch >= CH_A && ch <= CH_Z;
  assign is_digit = ch >= CH_0 && ch <= CH_9;
  assign is_term  = ch == CH_LF || ch == CH_CR;
  assign dsub     = ch - CH_0;
  assign num_mul  = {4'h0, num_reg} * NUM_TEN + {7'h00, dsub[3:0]};
  assign num_sat  = (num_mul > {4'h0, NUM_SAT}) ? NUM_SAT : num_mul[6:0];

  // ****************************************************************
  // Keyword table lookup
  // ****************************************************************
  for (genvar k = 1; k <= KW_NUM; k++) begin : g_kw
    localparam int LL = kw_len(KW_NAME[k]);
    localparam int SL = kw_short(KW_NAME[k]);
    logic par_ok;
    logic form_ok;
    assign par_ok  = cur_reg == KW_PA[k] || cur_reg == KW_PB[k] ||
                     (cur_reg == KW_ROOT && (KW_PA[k] == KW_SOUR || KW_PB[k] == KW_SOUR));
    assign form_ok = (len_reg == 4'(LL) && buf_reg == KW_NAME[k]) ||
                     (len_reg == 4'(SL) && buf_reg == (KW_NAME[k] >> (8 * (LL - SL))));
    assign hit[k]  = par_ok && form_ok;
  end

  always_comb begin
    kw_found = KW_ROOT;
    for (int k = 1; k <= KW_NUM; k++) begin
      if (hit[k]) kw_found = kw_id_t'(k);
    end
  end
  assign kw_ok = |hit;

  // ****************************************************************
  // Byte interpretation
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    kw_end     = 1'b0;
    node_end   = 1'b0;
    unit_end   = 1'b0;
    pbyte      = 1'b0;
    perr       = 1'b0;
    go_root    = 1'b0;
    if (step) begin
      case (state_reg)
        ST_START: begin
          if (is_term) begin
            perr = semi_reg;
          end else if (ch == CH_COLON) begin
            go_root    = 1'b1;
            state_next = ST_WORD;
          end else if (is_alpha) begin
            state_next = ST_WORD;
          end else begin
            perr = 1'b1;
          end
        end
        ST_WORD, ST_NODE, ST_TAIL: begin
          if (state_reg == ST_WORD && is_alpha) begin
            state_next = ST_WORD;
          end else if (state_reg == ST_WORD && is_digit) begin
            kw_end     = 1'b1;
            state_next = ST_NODE;
          end else if (state_reg == ST_NODE && is_digit) begin
            state_next = ST_NODE;
          end else begin
            kw_end   = state_reg == ST_WORD;
            node_end = state_reg == ST_NODE;
            if (ch == CH_COLON && state_reg != ST_TAIL) begin
              state_next = ST_WORD;
            end else if (ch == CH_QUERY && state_reg != ST_TAIL) begin
              state_next = ST_TAIL;
            end else if (ch == CH_SPACE) begin
              state_next = ST_PARAM;
            end else if (ch == CH_SEMI || is_term) begin
              unit_end   = 1'b1;
              state_next = ST_START;
            end else begin
              perr = 1'b1;
            end
          end
        end
        ST_PARAM: begin
          if (ch == CH_SEMI || is_term) begin
            unit_end   = 1'b1;
            state_next = ST_START;
          end else begin
            pbyte = 1'b1;
          end
        end
        ST_SKIP: begin
          if (is_term) state_next = ST_START;
        end
        default: state_next = ST_START;
      endcase
      if (kw_end && (len_reg == 4'h0 || !kw_ok)) perr = 1'b1;
      if (node_end && (num_reg < NODE_MIN || num_reg > NODE_MAX)) perr = 1'b1;
      if (unit_end && state_reg == ST_PARAM && last_reg == KW_SEL &&
          !(pdig_reg && num_reg >= NODE_MIN && num_reg <= NODE_MAX)) perr = 1'b1;
      if (state_reg == ST_SKIP) perr = 1'b0;
      if (is_term) go_root = 1'b1;
      if (perr) state_next = is_term ? ST_START : ST_SKIP;
    end
  end

  assign sel_fire = unit_end && state_reg == ST_PARAM && last_reg == KW_SEL;
  assign node_now = node_end ? num_reg[4:0] : node_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_START;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************************************
  // Keyword buffer
  // ****************************************************************
  // Overlong words saturate the length so that no entry can match
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      buf_reg <= '0;
      len_reg <= 4'h0;
    end else if (step && state_next == ST_WORD) begin
      if (!is_alpha) begin
        buf_reg <= '0;
        len_reg <= 4'h0;
      end else if (state_reg != ST_WORD) begin
        buf_reg <= {{(KW_BUF_W-8){1'b0}}, ch};
        len_reg <= 4'h1;
      end else begin
        buf_reg <= {buf_reg[KW_BUF_W-9:0], ch};
        len_reg <= (len_reg == LEN_SAT) ? len_reg : len_reg + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Tree position
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_reg  <= KW_ROOT;
      base_reg <= KW_ROOT;
      last_reg <= KW_ROOT;
    end else if (step) begin
      if (kw_end && !perr) last_reg <= kw_found;
      if (go_root) begin
        cur_reg  <= KW_ROOT;
        base_reg <= KW_ROOT;
      end else if (!perr && kw_end) begin
        base_reg <= cur_reg;
        cur_reg  <= unit_end ? cur_reg : kw_found;
      end else if (!perr && unit_end) begin
        cur_reg <= base_reg;
      end
    end
  end

  // ****************************************************************
  // Node number and message flags
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      num_reg  <= 7'h00;
      pdig_reg <= 1'b0;
    end else if (step) begin
      if (state_next == ST_NODE && state_reg != ST_NODE) begin
        num_reg <= {3'h0, dsub[3:0]};
      end else if (state_reg == ST_NODE && is_digit) begin
        num_reg <= num_sat;
      end else if (state_next == ST_PARAM && state_reg != ST_PARAM) begin
        num_reg  <= 7'h00;
        pdig_reg <= 1'b0;
      end else if (pbyte && is_digit) begin
        num_reg  <= num_sat;
        pdig_reg <= 1'b1;
      end else if (pbyte && ch != CH_SPACE) begin
        pdig_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      node_reg <= NODE_RESET;
    end else if (step && !perr) begin
      if (node_end) begin
        node_reg <= num_reg[4:0];
      end else if (sel_fire) begin
        node_reg <= num_reg[4:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      query_reg <= 1'b0;
      cr_reg    <= 1'b0;
      semi_reg  <= 1'b0;
    end else begin
      if (take) cr_reg <= f_data == CH_CR;
      if (step) begin
        semi_reg <= unit_end && ch == CH_SEMI;
        if (state_reg == ST_START) query_reg <= 1'b0;
        else if (state_next == ST_TAIL && state_reg != ST_TAIL) query_reg <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Result channel
  // ****************************************************************
  // Units go out as they close; the consumer acts only after cmd_eom
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_valid_reg <= 1'b0;
      cmd_param_reg <= 1'b0;
      cmd_byte_reg  <= 8'h00;
      cmd_kw_reg    <= KW_ROOT;
      cmd_query_reg <= 1'b0;
      cmd_node_reg  <= NODE_RESET;
      cmd_eom_reg   <= 1'b0;
      parse_err_reg <= 1'b0;
    end else begin
      parse_err_reg <= step && perr;
      if (cmd_ready) cmd_valid_reg <= 1'b0;
      if (step && !perr && (unit_end || pbyte)) begin
        cmd_valid_reg <= 1'b1;
        cmd_param_reg <= pbyte;
        cmd_byte_reg  <= f_data;
        cmd_kw_reg    <= kw_end ? kw_found : last_reg;
        cmd_query_reg <= query_reg;
        cmd_node_reg  <= sel_fire ? num_reg[4:0] : node_now;
        cmd_eom_reg   <= unit_end && is_term;
      end
    end
  end

  assign cmd_valid = cmd_valid_reg;
  assign cmd_param = cmd_param_reg;
  assign cmd_byte  = cmd_byte_reg;
  assign cmd_kw    = cmd_kw_reg;
  assign cmd_query = cmd_query_reg;
  assign cmd_node  = cmd_node_reg;
  assign cmd_eom   = cmd_eom_reg;
  assign parse_err = parse_err_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  root_on_term_a: assert property (step && is_term |=> cur_reg == KW_ROOT)
    else $error("tree not at root after terminator");
  root_spec_a: assert property (
    step && state_reg == ST_START && ch == CH_COLON |=> cur_reg == KW_ROOT && state_reg == ST_WORD)
    else $error("root colon did not reset tree");
  sep_descend_a: assert property (
    step && !perr && state_reg == ST_WORD && ch == CH_COLON |=> cur_reg == $past(kw_found))
    else $error("separator did not descend");
  semi_level_a: assert property (
    step && !perr && state_reg == ST_TAIL && ch == CH_SEMI
    |=> cur_reg == $past(base_reg) && cmd_valid && !cmd_param)
    else $error("unit split at wrong level");
  bad_kw_err_a: assert property (step && kw_end && !kw_ok |=> parse_err ##1 !parse_err)
    else $error("bad keyword not flagged");
  query_flag_a: assert property (
    step && !perr && state_reg == ST_WORD && ch == CH_QUERY |=> state_reg == ST_TAIL && query_reg)
    else $error("query not marked");
  term_eom_a: assert property (step && !perr && unit_end && is_term |=> cmd_valid && cmd_eom)
    else $error("terminator did not close message");
  node_range_a: assert property (node_reg >= NODE_MIN[4:0] && node_reg <= NODE_MAX[4:0])
    else $error("node out of range");
  node_take_a: assert property (step && !perr && node_end |=> node_reg == $past(node_now))
    else $error("appended node not kept");
  skip_hold_a: assert property (
    state_reg == ST_SKIP && !(step && is_term) |=> state_reg == ST_SKIP && !$rose(cmd_valid))
    else $error("discard ended early");
  param_pass_a: assert property (
    step && !perr && pbyte |=> cmd_param && cmd_byte == $past(f_data))
    else $error("parameter byte lost");
  stall_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_byte))
    else $error("result dropped while stalled");

  query_seen_c: cover property (cmd_valid && cmd_query && cmd_eom);
  sel_seen_c: cover property (step && !perr && sel_fire);
  error_seen_c: cover property (parse_err);
  fifo_full_c: cover property (!rx_ready);
endmodule : ascii_command_message_parser

// file: dv/host_msg_model.sv
// Host controller model that sends ASCII program messages byte by byte
`timescale 1ns/100ps
module host_msg_model (
  input  wire logic       ref_clk,
  input  wire logic       rx_ready,
  output      logic       rx_valid,
  output      logic [7:0] rx_data
);
  logic rdy_seen;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // Ready moves only on rising edges, so the falling edge value is what the next edge sees
  always @(negedge ref_clk) rdy_seen <= rx_ready;
  // Each byte held until taken; caller ends every message with a terminator
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      rx_valid <= 1'b1;
      rx_data  <= s[i];
      do @(posedge ref_clk); while (!rdy_seen);
    end
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;  // Released line never shows a stale byte
  endtask : send
endmodule : host_msg_model

// file: dv/ascii_command_message_parser_tb.sv
// Self-checking bench for the ASCII command message parser
`timescale 1ns/100ps
module ascii_command_message_parser_tb;
  import ascii_cmd_pkg::*;
  logic        ref_clk, rst_b, rx_valid, rx_ready, cmd_valid, cmd_ready;
  logic        cmd_param, cmd_query, cmd_eom, parse_err;
  logic [7:0]  rx_data, cmd_byte;
  kw_id_t      cmd_kw;
  node_t       cmd_node;
  logic [20:0] resq [$];
  int          n_fail, checks_done, n_err, cyc;

  host_msg_model u_host_msg_model (.ref_clk(ref_clk), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data));
  ascii_command_message_parser u_ascii_command_message_parser (.ref_clk(ref_clk),
    .rst_b(rst_b), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_param(cmd_param),
    .cmd_byte(cmd_byte), .cmd_kw(cmd_kw), .cmd_query(cmd_query), .cmd_node(cmd_node),
    .cmd_eom(cmd_eom), .parse_err(parse_err));

  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  // ****************************************************************
  // Result collector and timeout
  // ****************************************************************
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1)
      resq.push_back({cmd_param, cmd_byte, cmd_kw, cmd_query, cmd_node, cmd_eom});
    if (parse_err === 1'b1) n_err++;
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // ****************************************************************
  // Compare helpers
  // ****************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_res(input logic [20:0] exp);
    logic [20:0] got;
    got = (resq.size() > 0) ? resq.pop_front() : 21'h1FFFFF;
    chk_val({11'h000, got}, {11'h000, exp});
  endtask : chk_res

  // Parameter bytes carry the unit's keyword and the node in force while they arrive
  task automatic chk_param(input logic [7:0] b, kw_id_t k, node_t n);
    chk_res({1'b1, b, k, 1'b0, n, 1'b0});
  endtask : chk_param

  task automatic chk_unit(input logic [7:0] b, kw_id_t k, logic q, node_t n, logic e);
    chk_res({1'b0, b, k, q, n, e});
  endtask : chk_unit

  // Waits until results have stopped for 8 cycles, bounded
  task automatic msg(input string s);
    int idle;
    idle = 0;
    u_host_msg_model.send(s);
    for (int k = 0; k < 300 && idle < 8; k++) begin
      @(posedge ref_clk);
      idle = (cmd_valid === 1'b0) ? idle + 1 : 0;
    end
  endtask : msg

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_forms;
    msg("VOLT 5\n");
    chk_param(8'h35, 5'h07, 5'h01);
    chk_unit(CH_LF, 5'h07, 1'b0, 5'h01, 1'b1);
    msg("vOlTaGe 5\r");
    chk_param(8'h35, 5'h07, 5'h01);
    chk_unit(CH_CR, 5'h07, 1'b0, 5'h01, 1'b1);
    msg("meas:curr?\r\n");
    chk_unit(CH_CR, 5'h08, 1'b1, 5'h01, 1'b1);
    chk_val(resq.size(), 0);
    $display("t_forms done");
  endtask : t_forms

  task automatic t_tree;
    msg("STAT:OPER:COND?;ENAB 16\n");
    chk_unit(CH_SEMI, 5'h0F, 1'b1, 5'h01, 1'b0);
    chk_param(8'h31, 5'h10, 5'h01);
    chk_param(8'h36, 5'h10, 5'h01);
    chk_unit(CH_LF, 5'h10, 1'b0, 5'h01, 1'b1);
    msg("MEAS:VOLT?;:CURR?\n");
    chk_unit(CH_SEMI, 5'h07, 1'b1, 5'h01, 1'b0);
    chk_unit(CH_LF, 5'h08, 1'b1, 5'h01, 1'b1);
    msg("STAT:PRES\n");
    chk_unit(CH_LF, 5'h0D, 1'b0, 5'h01, 1'b1);
    msg("VOLT?\n");
    chk_unit(CH_LF, 5'h07, 1'b1, 5'h01, 1'b1);
    $display("t_tree done");
  endtask : t_tree

  task automatic t_node;
    msg("meas:volt3?\n");
    chk_unit(CH_LF, 5'h07, 1'b1, 5'h03, 1'b1);
    msg("VOLT?\n");
    chk_unit(CH_LF, 5'h07, 1'b1, 5'h03, 1'b1);
    msg("INST:SEL 10\n");
    chk_param(8'h31, 5'h0B, 5'h03);
    chk_param(8'h30, 5'h0B, 5'h03);
    chk_unit(CH_LF, 5'h0B, 1'b0, 5'h0A, 1'b1);
    msg("CURR?\n");
    chk_unit(CH_LF, 5'h08, 1'b1, 5'h0A, 1'b1);
    msg("VOLT31?\n");
    chk_unit(CH_LF, 5'h07, 1'b1, 5'h1F, 1'b1);
    $display("t_node done");
  endtask : t_node

  task automatic t_err;
    string bad [5];
    int    e0;
    bad = '{"IMME\n", "VOLTA\n", "FOO\n", "VOLT32?\n", "VOLT::LEV?\n"};
    e0  = n_err;
    foreach (bad[i]) msg(bad[i]);
    chk_val(n_err - e0, 5);
    chk_val(resq.size(), 0);
    msg("VOLT 1;FOO;CURR?\n");
    chk_param(8'h31, 5'h07, 5'h1F);
    chk_unit(CH_SEMI, 5'h07, 1'b0, 5'h1F, 1'b0);
    chk_val(resq.size(), 0);
    chk_val(n_err - e0, 6);
    msg("volt:lev?\n");
    chk_unit(CH_LF, 5'h12, 1'b1, 5'h1F, 1'b1);
    $display("t_err done");
  endtask : t_err

  // Consumer stalls so the input FIFO fills and refuses
  task automatic t_fill;
    string s;
    s = "VOLT ";
    for (int i = 0; i < 40; i++) s = {s, "7"};
    cmd_ready <= 1'b0;
    fork
      u_host_msg_model.send({s, "\n"});
    join_none
    for (int k = 0; k < 200 && rx_ready !== 1'b0; k++) @(posedge ref_clk);
    chk_val(rx_ready, 1'b0);
    chk_val(cmd_valid, 1'b1);
    cmd_ready <= 1'b1;
    wait fork;
    msg("");
    for (int i = 0; i < 40; i++) chk_param(8'h37, 5'h07, 5'h1F);
    chk_unit(CH_LF, 5'h07, 1'b0, 5'h1F, 1'b1);
    $display("t_fill done");
  endtask : t_fill

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    rst_b     = 1'b0;
    cmd_ready = 1'b1;
    repeat (10) @(posedge ref_clk);
    chk_val(rx_ready, 1'b1);
    chk_val(cmd_valid, 1'b0);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    chk_val(cmd_node, 5'h01);
    t_forms();
    t_tree();
    t_node();
    t_err();
    t_fill();
    end_sim();
  end
endmodule : ascii_command_message_parser_tb
